// ==== hw/pcms_map.svh ====
`ifndef PCMS_MAP_SVH
`define PCMS_MAP_SVH
// ****************************************
// timing base
// ****************************************
`define PCMS_CLK_MHZ       250
// frequency clamp, least time, rounded up
`define PCMS_CLAMP_NS      7700
`define PCMS_CLAMP_CYC     ((`PCMS_CLAMP_NS * `PCMS_CLK_MHZ + 999) / 1000)
// continuous-mode period
`define PCMS_CCM_KHZ       65
`define PCMS_CCM_CYC       ((`PCMS_CLK_MHZ * 1000) / `PCMS_CCM_KHZ)
`define PCMS_LONG_PCT      112
`define PCMS_LONG_CYC      ((`PCMS_CCM_CYC * `PCMS_LONG_PCT) / 100)
`define PCMS_RUN_LEN       8
// continuous-mode hold time
`define PCMS_HOLD_MS       360
`define PCMS_HOLD_CYC      (`PCMS_HOLD_MS * `PCMS_CLK_MHZ * 1000)
// minimum-frequency clock and valley timeout
`define PCMS_MINF_NS       33000
`define PCMS_MINF_CYC      ((`PCMS_MINF_NS * `PCMS_CLK_MHZ) / 1000)
`define PCMS_VTO_NS        3000
`define PCMS_VTO_CYC       ((`PCMS_VTO_NS * `PCMS_CLK_MHZ) / 1000)
// ****************************************
// foldback phase accumulator
// ****************************************
`define PCMS_ACC_W         24
`define PCMS_FOLD_DIV      10
`define PCMS_STEP_NOM      ((1 << `PCMS_ACC_W) / `PCMS_CLAMP_CYC)
`define PCMS_STEP_MIN      (`PCMS_STEP_NOM / `PCMS_FOLD_DIV)
`define PCMS_STEP_SPAN     (`PCMS_STEP_NOM - `PCMS_STEP_MIN)
`define PCMS_FOLD_SHIFT_LL 7
`define PCMS_FOLD_SHIFT_HL 6
`endif

// ==== hw/pcms_pkg.sv ====
package pcms_pkg;
  // ****************************************
  // types
  // ****************************************
  // switching sequencer states
  typedef enum logic [2:0] {
    PCMS_S_LOCK, PCMS_S_ON, PCMS_S_DEMAG, PCMS_S_WAIT, PCMS_S_MINV, PCMS_S_CCMW
  } pcms_state_t;
  // conduction mode of the last cycle
  typedef enum logic [1:0] {
    PCMS_MODE_OFF, PCMS_MODE_CRM, PCMS_MODE_DCM, PCMS_MODE_CCM
  } pcms_mode_t;
  // comparator indications from the analog side
  typedef struct packed {
    logic supply_below_off;
    logic supply_above_on;
    logic demag_done;
    logic valley_seen;
    logic on_time_end;
  } pcms_sense_t;
endpackage

// ==== hw/pcms_timer.sv ====
// ****************************************
// saturating interval timer
// ****************************************
module pcms_timer #(
  parameter int W     = 32,
  parameter int LIMIT = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic run,
  output logic      done
);
  logic [W-1:0] cnt;   // elapsed cycles
  wire          last = (cnt == W'(LIMIT - 1));

  // count while running, stop once done
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (run && !done) begin
      cnt  <= cnt + W'(1);
      done <= last;
    end
  end
endmodule

// ==== hw/pcms_core.sv ====
`include "pcms_map.svh"
// Functional notes
// - startup source on below supply off level
// - above on level: source off, start switching
// - critical mode until clamp frequency exceeded
// - short cycle waits out the clamp period
// - discontinuous mode then waits for valley
// - mid-length cycle gives critical conduction
// - eight cycles over 112 percent enter continuous
// - leave continuous after hold time without run
// - continuous held whole line for hold time
// - critical/discontinuous change cycle by cycle
// - turn-on valley chosen automatically per cycle
// - low demand stretches clamp, high line half
// - clamp frequency linear down to one tenth
// - minimum-frequency clock at 33 us period
// - then valley, forced on after 3 us
// - min clock only in dead time, never continuous
// - cycle length is on-time plus demagnetization
module pcms_core
  import pcms_pkg::*;
#(
  parameter int HOLD_CYCLES = `PCMS_HOLD_CYC,
  parameter int MINF_CYCLES = `PCMS_MINF_CYC,
  parameter int LONG_CYCLES = `PCMS_LONG_CYC,
  parameter int DEMAND_W    = 8
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire pcms_sense_t         sense,
  input  wire logic [DEMAND_W-1:0] power_demand,
  input  wire logic                high_line,
  output logic                     gate_drive_out,
  output logic                     startup_source_on,
  output logic                     clamped_critical_mode,
  output pcms_mode_t               conduction_mode
);
  // ****************************************
  // local constants
  // ****************************************
  localparam int CW      = 16;                   // cycle counter width
  localparam int CCM_CYC = `PCMS_CCM_CYC;        // continuous period
  localparam int VTO_CYC = `PCMS_VTO_CYC;        // valley timeout
  localparam int RUN_LEN = `PCMS_RUN_LEN;        // run length
  localparam int AW      = `PCMS_ACC_W;          // accumulator width

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int SN = $bits(pcms_sense_t);
  logic [SN-1:0] sync1;                          // first stage, read by sync2 only
  logic [SN-1:0] sync2;                          // stable copy
  wire  [SN-1:0] sense_bits = sense;
  pcms_sense_t   s;
  assign s = sync2;

  // two flops per comparator bit
  for (genvar i = 0; i < SN; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (rst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else begin
        sync1[i] <= sense_bits[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  // ****************************************
  // state
  // ****************************************
  pcms_state_t    state;                          // sequencer state
  pcms_state_t    next_state;
  logic           running;                        // lockout released
  logic           ccm_mode;                       // continuous conduction
  logic [CW-1:0]  cyc_cnt;                        // cycles since turn-on
  logic [AW:0]    acc;                            // clamp phase, msb = expired
  logic [3:0]     run;                            // consecutive long cycles
  logic           minstart;                       // cycle began on min clock
  logic           blank_done;                     // hold time elapsed
  logic           vto_done;                       // valley wait timed out

  // ****************************************
  // decoding
  // ****************************************
  // hysteresis band: set above on level, clear below off level
  wire running_set   = !running && s.supply_above_on && !s.supply_below_off;
  wire clamp_done    = acc[AW];
  wire min_clk       = (cyc_cnt >= CW'(MINF_CYCLES - 1));
  wire ccm_end       = (cyc_cnt >= CW'(CCM_CYC - 1));
  // cycle ends at demag, or at period end in continuous mode
  wire meas_evt      = (state == PCMS_S_DEMAG) && (s.demag_done || (ccm_mode && ccm_end));
  // in continuous mode a cycle cut off at the period end had no demag: long
  wire long_ccm      = ccm_end;
  wire long_entry    = (cyc_cnt > CW'(LONG_CYCLES)) && !minstart;
  wire long_ok       = ccm_mode ? long_ccm : long_entry;
  wire run_hit       = long_ok && (run == 4'(RUN_LEN - 1));
  wire ccm_enter     = meas_evt && !ccm_mode && run_hit;
  wire blank_restart = meas_evt && ccm_mode && run_hit;
  wire start         = (next_state == PCMS_S_ON) && (state != PCMS_S_ON);

  // foldback: threshold halves on high line
  wire [2:0]          fold_shift = high_line ? 3'(`PCMS_FOLD_SHIFT_HL) : 3'(`PCMS_FOLD_SHIFT_LL);
  wire [DEMAND_W:0]   fold_thr   = (DEMAND_W + 1)'(1) << fold_shift;
  wire [DEMAND_W:0]   demand_ext = {1'b0, power_demand};
  wire [DEMAND_W:0]   demand_eff = (demand_ext > fold_thr) ? fold_thr : demand_ext;
  wire [31:0]         fold_prod  = 32'(`PCMS_STEP_SPAN) * 32'(demand_eff);
  // clamp frequency is linear in demand, floor at one tenth
  wire [15:0]         step       = 16'(`PCMS_STEP_MIN) + 16'(fold_prod >> fold_shift);

  // ****************************************
  // timers
  // ****************************************
  // hold time restarts on every run seen in continuous mode
  pcms_timer #(.W(32), .LIMIT(HOLD_CYCLES)) u_hold (
    .clk   (clk),
    .rst   (rst),
    .clear (blank_restart || !ccm_mode),
    .run   (ccm_mode),
    .done  (blank_done)
  );

  // valley wait after the minimum-frequency clock
  pcms_timer #(.W(CW), .LIMIT(VTO_CYC)) u_vto (
    .clk   (clk),
    .rst   (rst),
    .clear (state != PCMS_S_MINV),
    .run   (1'b1),
    .done  (vto_done)
  );

  // ****************************************
  // sequencer
  // ****************************************
  // next state of the switching cycle
  always_comb begin
    next_state = state;
    case (state)
      PCMS_S_LOCK: begin
        if (running) begin
          next_state = PCMS_S_ON;
        end
      end
      PCMS_S_ON: begin
        if (s.on_time_end) begin
          next_state = PCMS_S_DEMAG;
        end
      end
      PCMS_S_DEMAG: begin
        if (ccm_mode && ccm_end) begin
          next_state = PCMS_S_ON;
        end else if (s.demag_done && ccm_mode) begin
          next_state = PCMS_S_CCMW;
        end else if (s.demag_done && clamp_done) begin
          next_state = PCMS_S_ON;
        end else if (s.demag_done) begin
          next_state = PCMS_S_WAIT;
        end
      end
      PCMS_S_WAIT: begin
        // dead time only: min clock cannot cut a pulse short
        if (min_clk) begin
          next_state = PCMS_S_MINV;
        end else if (clamp_done && s.valley_seen) begin
          // first valley after clamp expiry, so it shifts by itself
          next_state = PCMS_S_ON;
        end
      end
      PCMS_S_MINV: begin
        if (s.valley_seen || vto_done) begin
          next_state = PCMS_S_ON;
        end
      end
      PCMS_S_CCMW: begin
        if (!ccm_mode) begin
          next_state = PCMS_S_WAIT;
        end else if (ccm_end) begin
          next_state = PCMS_S_ON;
        end
      end
      default: begin
        next_state = PCMS_S_LOCK;
      end
    endcase
    // supply loss stops the gate at once, not one cycle after running falls
    if (!running || s.supply_below_off) begin
      next_state = PCMS_S_LOCK;
    end
  end

  // state, supply lockout and gate drive
  always_ff @(posedge clk) begin
    if (rst) begin
      state          <= PCMS_S_LOCK;
      running        <= 1'b0;
      gate_drive_out <= 1'b0;
    end else begin
      state          <= next_state;
      running        <= !s.supply_below_off && (running || running_set);
      gate_drive_out <= (next_state == PCMS_S_ON) && running;
    end
  end

  assign startup_source_on     = !running;
  assign clamped_critical_mode = running && !ccm_mode;

  // cycle length counter and clamp accumulator
  always_ff @(posedge clk) begin
    if (rst || start) begin
      cyc_cnt <= '0;
      acc     <= '0;
    end else begin
      if (cyc_cnt != '1) begin
        cyc_cnt <= cyc_cnt + CW'(1);
      end
      if (!clamp_done) begin
        acc <= acc + (AW + 1)'(step);
      end
    end
  end

  // min-clock cycles are flagged so they never count as long outside continuous mode
  always_ff @(posedge clk) begin
    if (rst) begin
      minstart <= 1'b0;
    end else if (start) begin
      minstart <= (state == PCMS_S_MINV);
    end
  end

  // ****************************************
  // mode selection
  // ****************************************
  // run counter and continuous-mode flag
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      run      <= '0;
      ccm_mode <= 1'b0;
    end else begin
      if (meas_evt) begin
        if (!long_ok || run_hit) begin
          run <= '0;
        end else begin
          run <= run + 4'(1);
        end
      end else if (ccm_mode && blank_done) begin
        run <= '0;
      end
      if (ccm_enter) begin
        ccm_mode <= 1'b1;
      end else if (blank_done && !blank_restart) begin
        ccm_mode <= 1'b0;
      end
    end
  end

  // mode of the last measured cycle, may change every cycle
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      conduction_mode <= PCMS_MODE_OFF;
    end else if (meas_evt && ccm_mode) begin
      conduction_mode <= PCMS_MODE_CCM;
    end else if (meas_evt) begin
      conduction_mode <= clamp_done ? PCMS_MODE_CRM : PCMS_MODE_DCM;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_src_low;
    s.supply_below_off |=> startup_source_on && !gate_drive_out;
  endproperty
  a_src_low: assert property (p_src_low) else $error("source off below supply level");

  property p_start_up;
    !running && s.supply_above_on && !s.supply_below_off |=> !startup_source_on ##1 gate_drive_out;
  endproperty
  a_start_up: assert property (p_start_up) else $error("no start above on level");

  property p_clamp;
    start && !ccm_mode && (state != PCMS_S_LOCK) |-> clamp_done || (state == PCMS_S_MINV);
  endproperty
  a_clamp: assert property (p_clamp) else $error("turn-on before clamp period");

  property p_valley;
    start && (state == PCMS_S_WAIT) |-> s.valley_seen && clamp_done;
  endproperty
  a_valley: assert property (p_valley) else $error("dcm turn-on off valley");

  property p_enter;
    meas_evt && !ccm_mode && long_entry && (run == 4'(RUN_LEN - 1)) |=> ccm_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("continuous mode not entered");

  property p_exit;
    $fell(ccm_mode) && running |-> $past(blank_done);
  endproperty
  a_exit: assert property (p_exit) else $error("continuous mode left early");

  property p_leave;
    ccm_mode && blank_done && !meas_evt && running && !s.supply_below_off |=> !ccm_mode;
  endproperty
  a_leave: assert property (p_leave) else $error("continuous mode kept after hold");

  property p_minclk;
    (state == PCMS_S_WAIT) && min_clk && running && !s.supply_below_off |=> state == PCMS_S_MINV;
  endproperty
  a_minclk: assert property (p_minclk) else $error("minimum-frequency clock missed");

  property p_force;
    (state == PCMS_S_MINV) && vto_done && running && !s.supply_below_off |=> gate_drive_out;
  endproperty
  a_force: assert property (p_force) else $error("gate not forced after timeout");

  property p_deadtime;
    (state == PCMS_S_MINV) |-> $past(state) inside {PCMS_S_WAIT, PCMS_S_MINV};
  endproperty
  a_deadtime: assert property (p_deadtime) else $error("min clock outside dead time");

  property p_run_clr;
    meas_evt && !long_ok && running && !s.supply_below_off |=> run == 4'h0;
  endproperty
  a_run_clr: assert property (p_run_clr) else $error("run not cleared");

  c_enter: cover property ($rose(ccm_mode));
  c_exit:  cover property ($fell(ccm_mode) && running);
  c_force: cover property ((state == PCMS_S_MINV) && vto_done);
  c_dcm:   cover property (start && (state == PCMS_S_WAIT));
endmodule

// ==== verification/pcms_plant.sv ====
// ****************************************
// power stage stand-in: switch, inductor, comparators
// ****************************************
module pcms_plant
  import pcms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        gate_drive_out,
  input  wire logic        supply_up,
  input  wire logic [15:0] on_len,
  input  wire logic [15:0] demag_len,
  input  wire logic        valley_on,
  output pcms_sense_t      sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] on_cnt  = 16'h0000; // cycles since gate rose
  logic [15:0] off_cnt = 16'h0000; // cycles since gate fell
  logic [15:0] ring;               // time since demagnetization
  logic        on_end;             // current-sense trip
  logic        demag;              // zero-current seen
  logic        valley;             // drain ringing at a minimum
  // count on the falling edge, away from the design's sampling edge
  always @(negedge clk) begin
    if (gate_drive_out) begin
      on_cnt  <= on_cnt + 16'h0001;
      off_cnt <= 16'h0000;
    end else begin
      // saturate so a long idle never wraps into a false demag
      off_cnt <= off_cnt + {15'h0000, off_cnt != 16'hffff};
      on_cnt  <= 16'h0000;
    end
  end
  assign ring   = off_cnt - demag_len;
  assign on_end = gate_drive_out && (on_cnt >= on_len);
  // demag only after the gate is off: a ccm turn-on cuts it short
  assign demag  = !gate_drive_out && (off_cnt >= demag_len);
  // drain rings only once the inductor is empty, one valley every 64 cycles
  assign valley = demag && valley_on && (ring[5:0] >= 6'h3c);
  // the two supply comparators never both fire
  assign sense  = {!supply_up, supply_up, demag, valley, on_end};
endmodule

// ==== verification/pfc_conduction_mode_selector_tb_top.sv ====
module pfc_conduction_mode_selector_tb_top
  import pcms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bench signals
  // ****************************************
  localparam int HOLD = 10000;     // shortened continuous hold time
  localparam int LIM  = 12000;     // bound on any wait for the gate
  logic        clk       = 1'b0;   // 250 mhz
  logic        rst       = 1'b1;   // synchronous, active high
  logic        supply_up = 1'b0;   // supply above the on level
  logic [15:0] on_len    = 16'h012c;
  logic [15:0] dm_len    = 16'h012c;
  logic        valley_on = 1'b1;   // drain shows valleys
  logic [7:0]  power_demand = 8'hff;
  logic        high_line = 1'b0;
  pcms_sense_t sense;
  logic        gate_drive_out;
  logic        startup_source_on;
  logic        clamped_critical_mode;
  pcms_mode_t  conduction_mode;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          p;                  // measured period in cycles
  always #2 clk = ~clk;
  pcms_core #(.HOLD_CYCLES(HOLD), .MINF_CYCLES(8250), .LONG_CYCLES(4307), .DEMAND_W(8)) pcms_core_inst (
    .clk(clk), .rst(rst), .sense(sense), .power_demand(power_demand), .high_line(high_line),
    .gate_drive_out(gate_drive_out), .startup_source_on(startup_source_on),
    .clamped_critical_mode(clamped_critical_mode), .conduction_mode(conduction_mode));
  pcms_plant pcms_plant_inst (
    .clk(clk), .gate_drive_out(gate_drive_out), .supply_up(supply_up), .on_len(on_len),
    .demag_len(dm_len), .valley_on(valley_on), .sense(sense));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  // cycles until the next gate rise, bounded
  task automatic rise(output int n);
    n = 0;
    while (gate_drive_out !== 1'b0 && n < LIM) begin
      @(negedge clk);
      n++;
    end
    while (gate_drive_out !== 1'b1 && n < LIM) begin
      @(negedge clk);
      n++;
    end
    if (n >= LIM) check(32'h0, 32'h1, "gate stuck");
  endtask
  // run k whole cycles with given on and demag times
  task automatic cycles(input int k, input int on_t, input int dm_t);
    int n;
    on_len = 16'(on_t);
    dm_len = 16'(dm_t);
    repeat (k) rise(n);
  endtask
  // one cycle to settle, then one measured period
  task automatic meas(input int on_t, input int dm_t, output int per);
    cycles(1, on_t, dm_t);
    rise(per);
  endtask
  task automatic wait_src(input logic lvl, output int n);
    n = 0;
    while (startup_source_on !== lvl && n < 10) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_startup();
    int n;
    check(startup_source_on, 1, "source off in lockout");
    check(gate_drive_out, 0, "gate on in lockout");
    check(conduction_mode, PCMS_MODE_OFF, "mode in lockout");
    supply_up = 1'b1;
    wait_src(1'b0, n);
    check(inr(n, 2, 4), 1, "source release delay");
    check(clamped_critical_mode, 1, "not clamped mode");
    rise(n);
    check(inr(n, 0, 3), 1, "first gate late");
    $display("startup done");
  endtask
  task automatic t_crm_dcm();
    meas(1500, 800, p);
    check(inr(p, 2290, 2320), 1, "critical period");
    check(conduction_mode, PCMS_MODE_CRM, "critical mode");
    // short cycle: clamp then valley, next cycle already
    rise(p);
    on_len = 16'h012c;
    dm_len = 16'h012c;
    rise(p);
    check(inr(p, 1920, 1995), 1, "clamped period");
    check(conduction_mode, PCMS_MODE_DCM, "discontinuous");
    $display("crm dcm done");
  endtask
  task automatic t_fold();
    // high line, one-eighth demand: clamp stretched to about 3500
    high_line = 1'b1;
    power_demand = 8'h20;
    meas(300, 300, p);
    check(inr(p, 3480, 3570), 1, "foldback period");
    // no load and no valleys: min clock then forced turn-on
    high_line = 1'b0;
    power_demand = 8'h00;
    valley_on = 1'b0;
    meas(300, 300, p);
    check(inr(p, 8990, 9010), 1, "min clock timeout period");
    check(clamped_critical_mode, 1, "min clock left clamp");
    valley_on = 1'b1;
    power_demand = 8'hff;
    $display("foldback done");
  endtask
  task automatic continuous_period();
    // first cycle began on the min clock and never counts, then one long,
    // a short breaks the run, then seven long: eight longs only if unbroken
    cycles(2, 2500, 2000);
    cycles(1, 300, 300);
    cycles(7, 2500, 2000);
    check(clamped_critical_mode, 1, "broken run counted");
    cycles(1, 2500, 2000);
    check(clamped_critical_mode, 0, "no continuous entry");
    rise(p);
    check(inr(p, 3840, 3852), 1, "continuous period");
    // mode shows the last measured cycle, here the first continuous one
    check(conduction_mode, PCMS_MODE_CCM, "mode after run");
    $display("ccm entry done");
  endtask
  task automatic t_hold();
    int n;
    cycles(1, 300, 300);
    repeat (HOLD - 8000) @(negedge clk);
    check(clamped_critical_mode, 0, "left continuous early");
    n = 0;
    while (clamped_critical_mode !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    check(inr(n, 1, 8999), 1, "hold expiry");
    meas(300, 300, p);
    check(inr(p, 1920, 1995), 1, "clamp after return");
    $display("ccm hold done");
  endtask
  task automatic t_drop();
    int n;
    supply_up = 1'b0;
    wait_src(1'b1, n);
    check(inr(n, 2, 4), 1, "source restart delay");
    @(negedge clk);
    check(gate_drive_out, 0, "gate after lockout");
    $display("supply drop done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_startup();
    t_crm_dcm();
    t_fold();
    continuous_period();
    t_hold();
    t_drop();
    complete_run();
  end
  // tests take about 95k cycles
  initial begin
    repeat (140000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
